// File: inc/ppc_pkg.sv
`default_nettype none
package ppc_pkg;
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NPINS  = 3;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_PIN1_CONTROL = 6'h19;
  localparam logic [5:0] IDX_PIN2_CONTROL = 6'h1A;
  localparam logic [5:0] IDX_PIN3_CONTROL = 6'h1B;
  localparam logic [5:0] IDX_PORT_CONFIG  = 6'h1C;
  localparam logic [5:0] IDX_PORT_STATUS  = 6'h1D;

  // Port configuration fields
  localparam int CFG_PULL_DIRECTION_SELECT = 0;
  localparam int CFG_EXTERNAL_CLOCK_SELECT = 1;
  // Port status fields
  localparam int STS_PIN_CHANGE_REQUEST_FLAG = 0;
  localparam int STS_PIN_LEVEL_LSB           = 1;

  // Reset values
  localparam logic [3:0]        CTRL_RST = 4'h0;
  localparam logic [1:0]        CFG_RST  = 2'h0;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // Level change sampling: 64 Hz time base at a 50 ns clock
  localparam longint SAMPLE_PERIOD_NS = 15625000;
  localparam longint CLK_PERIOD_NS    = 50;
  localparam int     SAMPLE_CYCLES    = int'(SAMPLE_PERIOD_NS / CLK_PERIOD_NS);
  localparam int     SAMPLE_CNT_W     = 19;

  // Per-pin control register, bit 3 down to bit 0
  typedef struct packed {
    logic irq_enable;
    logic alt_select;
    logic direction;
    logic drive_mode;
  } ppc_ctrl_t;

  // Pad-side drive of one pin
  typedef struct packed {
    logic pin_out;
    logic pin_oe;
    logic pull_up_en;
    logic pull_down_en;
  } ppc_pad_t;
endpackage
`default_nettype wire

// File: design/ppc_port4_pin_control.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ppc_port4_pin_control #(
  parameter int SAMPLE_DIV = ppc_pkg::SAMPLE_CYCLES
) (
  input  wire logic                        CLK,
  input  wire logic                        SRST,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [ppc_pkg::ADDR_W-1:0]  PADDR,
  input  wire logic [ppc_pkg::DATA_W-1:0]  PWDATA,
  output var  logic [ppc_pkg::DATA_W-1:0]  PRDATA,
  output var  logic                        PREADY,
  output var  logic                        PSLVERR,
  input  wire logic [ppc_pkg::NPINS-1:0]   PIN_IN,
  output var  logic [ppc_pkg::NPINS-1:0]   PIN_OUT,
  output var  logic [ppc_pkg::NPINS-1:0]   PIN_OE,
  output var  logic [ppc_pkg::NPINS-1:0]   PULL_UP_EN,
  output var  logic [ppc_pkg::NPINS-1:0]   PULL_DOWN_EN,
  input  wire logic [ppc_pkg::NPINS-1:0]   PORT_DATA,
  input  wire logic                        SERIAL_DATA_READY,
  input  wire logic                        SERIAL_CLK_OUT,
  output var  logic                        SERIAL_CLK_IN,
  input  wire logic                        OSC_RC_CLK,
  output var  logic                        PIN_CHANGE_INTERRUPT
);

  localparam int NP = ppc_pkg::NPINS;

  ppc_pkg::ppc_ctrl_t ctrl [NP];
  logic [1:0]         port_config;
  logic               flag;
  logic [NP-1:0]      pin_meta;
  logic [NP-1:0]      pin_sync;
  logic [NP-1:0]      pin_last;
  logic               osc_meta;
  logic               osc_sync;
  logic [ppc_pkg::SAMPLE_CNT_W-1:0] sample_cnt;
  logic               sample_tick;

  // Bus decode
  wire logic [5:0]  bus_idx    = PADDR[7:2];
  wire logic        bus_align  = (PADDR[1:0] == 2'h0);
  wire logic        bus_access = PSEL && PENABLE;
  wire logic        bus_done   = bus_access && PREADY;
  wire logic        hit_pin1   = bus_align && (bus_idx == ppc_pkg::IDX_PIN1_CONTROL);
  wire logic        hit_pin2   = bus_align && (bus_idx == ppc_pkg::IDX_PIN2_CONTROL);
  wire logic        hit_pin3   = bus_align && (bus_idx == ppc_pkg::IDX_PIN3_CONTROL);
  wire logic        hit_cfg    = bus_align && (bus_idx == ppc_pkg::IDX_PORT_CONFIG);
  wire logic        hit_sts    = bus_align && (bus_idx == ppc_pkg::IDX_PORT_STATUS);
  wire logic        hit_any    = hit_pin1 || hit_pin2 || hit_pin3 || hit_cfg || hit_sts;
  wire logic [NP-1:0] hit_ctrl = {hit_pin3, hit_pin2, hit_pin1};
  wire logic        wr_done    = bus_done && PWRITE;
  wire ppc_pkg::ppc_ctrl_t wr_ctrl = ppc_pkg::ppc_ctrl_t'(PWDATA[3:0]);

  wire logic pull_direction_select = port_config[ppc_pkg::CFG_PULL_DIRECTION_SELECT];
  wire logic external_clock_select = port_config[ppc_pkg::CFG_EXTERNAL_CLOCK_SELECT];

  // Control registers are write-only; they read back as zero
  wire logic [ppc_pkg::DATA_W-1:0] rd_word =
    hit_cfg ? {30'h0000_0000, port_config} :
    hit_sts ? {28'h000_0000, pin_sync, flag} :
    ppc_pkg::ZERO_WORD;

  wire logic next_ready = bus_access && !PREADY;
  wire logic next_err   = bus_access && !PREADY && !hit_any;

  // Secondary function routing per pin
  wire logic [NP-1:0] alt_data  = {osc_sync, SERIAL_CLK_OUT, SERIAL_DATA_READY};
  wire logic [NP-1:0] alt_drive = {1'b1, !external_clock_select, 1'b1};

  logic [NP-1:0] out_mode;
  logic [NP-1:0] irq_en;
  ppc_pkg::ppc_pad_t next_pad [NP];

  genvar g;
  generate
    for (g = 0; g < NP; g++)
    begin : g_pin
      wire logic data_src = ctrl[g].alt_select ? alt_data[g] : PORT_DATA[g];
      assign out_mode[g]  = ctrl[g].alt_select ? alt_drive[g] : ctrl[g].direction;
      assign irq_en[g]    = ctrl[g].irq_enable && !out_mode[g];
      // Open drain only ever pulls low
      assign next_pad[g].pin_out = out_mode[g] && !ctrl[g].drive_mode && data_src;
      assign next_pad[g].pin_oe  = out_mode[g] && (!ctrl[g].drive_mode || !data_src);
      assign next_pad[g].pull_up_en =
        !out_mode[g] && !ctrl[g].drive_mode && !pull_direction_select;
      assign next_pad[g].pull_down_en =
        !out_mode[g] && !ctrl[g].drive_mode && pull_direction_select;

      always_ff @(posedge CLK)
      begin
        if (SRST)
        begin
          ctrl[g]         <= ppc_pkg::ppc_ctrl_t'(ppc_pkg::CTRL_RST);
          PIN_OUT[g]      <= 1'b0;
          PIN_OE[g]       <= 1'b0;
          PULL_UP_EN[g]   <= 1'b0;
          PULL_DOWN_EN[g] <= 1'b0;
        end
        else
        begin
          if (wr_done && hit_ctrl[g])
          begin
            ctrl[g] <= wr_ctrl;
          end
          PIN_OUT[g]      <= next_pad[g].pin_out;
          PIN_OE[g]       <= next_pad[g].pin_oe;
          PULL_UP_EN[g]   <= next_pad[g].pull_up_en;
          PULL_DOWN_EN[g] <= next_pad[g].pull_down_en;
        end
      end
    end
  endgenerate

  // Level change detection at the sampling tick
  wire logic [NP-1:0] pin_change = (pin_sync ^ pin_last) & irq_en;
  wire logic any_change = sample_tick && (|pin_change);
  wire logic flag_clear = wr_done && hit_sts && PWDATA[ppc_pkg::STS_PIN_CHANGE_REQUEST_FLAG];
  wire logic next_flag  = any_change || (flag && !flag_clear);
  wire logic sample_wrap =
    (sample_cnt == ppc_pkg::SAMPLE_CNT_W'(SAMPLE_DIV - 1));

  // Bus slave
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      PREADY      <= 1'b0;
      PSLVERR     <= 1'b0;
      PRDATA      <= ppc_pkg::ZERO_WORD;
      port_config <= ppc_pkg::CFG_RST;
    end
    else
    begin
      PREADY  <= next_ready;
      PSLVERR <= next_err;
      PRDATA  <= (next_ready && !PWRITE) ? rd_word : ppc_pkg::ZERO_WORD;
      if (wr_done && hit_cfg)
      begin
        port_config <= PWDATA[1:0];
      end
    end
  end

  // Synchronisers for pins and oscillator clock
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
      osc_meta <= OSC_RC_CLK;
      osc_sync <= osc_meta;
    end
  end

  // 64 Hz sampling time base
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      sample_cnt  <= '0;
      sample_tick <= 1'b0;
    end
    else
    begin
      sample_cnt  <= sample_wrap ? '0 : sample_cnt + 1'b1;
      sample_tick <= sample_wrap;
    end
  end

  // Sampled level history and shared request flag
  always_ff @(posedge CLK)
  begin
    if (SRST)
    begin
      pin_last             <= '0;
      flag                 <= 1'b0;
      PIN_CHANGE_INTERRUPT <= 1'b0;
      SERIAL_CLK_IN        <= 1'b0;
    end
    else
    begin
      if (sample_tick)
      begin
        pin_last <= pin_sync;
      end
      flag                 <= next_flag;
      PIN_CHANGE_INTERRUPT <= next_flag;
      SERIAL_CLK_IN        <= ctrl[1].alt_select && external_clock_select && pin_sync[1];
    end
  end

  property p_ctrl_write;
    @(posedge CLK) disable iff (SRST)
    (wr_done && hit_pin1) |=> (ctrl[0] == $past(PWDATA[3:0]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("pin1 control not loaded from write data");

  property p_reset_clear;
    @(posedge CLK)
    SRST |=> (ctrl[0] == 4'h0) && (ctrl[1] == 4'h0) && (ctrl[2] == 4'h0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("control bits not cleared by reset");

  property p_flag_cause;
    @(posedge CLK) disable iff (SRST)
    $rose(flag) |-> $past(sample_tick && |((pin_sync ^ pin_last) & irq_en));
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("request flag set without enabled input change");

  property p_no_irq_output;
    @(posedge CLK) disable iff (SRST)
    (sample_tick && ((pin_sync ^ pin_last) & ~irq_en) != '0
      && ((pin_sync ^ pin_last) & irq_en) == '0 && !flag) |=> !flag;
  endproperty
  a_no_irq_output: assert property (p_no_irq_output)
    else $error("request from disabled or output pin");

  property p_change_sets;
    @(posedge CLK) disable iff (SRST)
    (sample_tick && |((pin_sync ^ pin_last) & irq_en)) |=> flag && PIN_CHANGE_INTERRUPT;
  endproperty
  a_change_sets: assert property (p_change_sets)
    else $error("enabled change did not set request flag");

  property p_tick_spacing;
    @(posedge CLK) disable iff (SRST)
    sample_tick |=> !sample_tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("sampling tick repeated too soon");

  property p_ready_forced;
    @(posedge CLK) disable iff (SRST)
    (ctrl[0].alt_select && !ctrl[0].drive_mode) |=> PIN_OE[0] && (PIN_OUT[0] == $past(SERIAL_DATA_READY));
  endproperty
  a_ready_forced: assert property (p_ready_forced)
    else $error("data-ready pin not driven");

  property p_sclk_dir;
    @(posedge CLK) disable iff (SRST)
    (ctrl[1].alt_select && external_clock_select) |=> !PIN_OE[1];
  endproperty
  a_sclk_dir: assert property (p_sclk_dir)
    else $error("serial clock pin driven while external clock");

  property p_mon_forced;
    @(posedge CLK) disable iff (SRST)
    (ctrl[2].alt_select && !ctrl[2].drive_mode) |=> PIN_OE[2];
  endproperty
  a_mon_forced: assert property (p_mon_forced)
    else $error("monitor pin not forced to output");

  property p_open_drain;
    @(posedge CLK) disable iff (SRST)
    (out_mode[0] && ctrl[0].drive_mode) |=> !PIN_OUT[0] && !PULL_UP_EN[0];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drove high");

  property p_pull_select;
    @(posedge CLK) disable iff (SRST)
    (!out_mode[2] && !ctrl[2].drive_mode) |=>
      (PULL_DOWN_EN[2] == $past(pull_direction_select)) && (PULL_UP_EN[2] != PULL_DOWN_EN[2]);
  endproperty
  a_pull_select: assert property (p_pull_select)
    else $error("pull resistor direction wrong");

  property p_plain_input;
    @(posedge CLK) disable iff (SRST)
    (!ctrl[1].alt_select && !ctrl[1].direction) |=> !PIN_OE[1];
  endproperty
  a_plain_input: assert property (p_plain_input)
    else $error("input pin driven");

  property p_flag_hold;
    @(posedge CLK) disable iff (SRST)
    (flag && !flag_clear) |=> flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("request flag dropped without clear");

  property p_ie_zero;
    @(posedge CLK) disable iff (SRST)
    (!ctrl[0].irq_enable && !ctrl[1].irq_enable && !ctrl[2].irq_enable && !flag) |=> !flag;
  endproperty
  a_ie_zero: assert property (p_ie_zero)
    else $error("request flag set with all enables clear");

  property p_sclk_out;
    @(posedge CLK) disable iff (SRST)
    (ctrl[1].alt_select && !external_clock_select && !ctrl[1].drive_mode) |=>
      PIN_OE[1] && (PIN_OUT[1] == $past(SERIAL_CLK_OUT));
  endproperty
  a_sclk_out: assert property (p_sclk_out)
    else $error("serial clock not driven out");

  property p_osc_out;
    @(posedge CLK) disable iff (SRST)
    (ctrl[2].alt_select && !ctrl[2].drive_mode) |=> PIN_OUT[2] == $past(osc_sync);
  endproperty
  a_osc_out: assert property (p_osc_out)
    else $error("oscillator clock not on monitor pin");

  property p_hiz_input;
    @(posedge CLK) disable iff (SRST)
    (!out_mode[1] && ctrl[1].drive_mode) |=> !PIN_OE[1] && !PULL_UP_EN[1] && !PULL_DOWN_EN[1];
  endproperty
  a_hiz_input: assert property (p_hiz_input)
    else $error("high-impedance input has a pull or drive");

endmodule
`default_nettype wire

// File: dv/ppc_board_model.sv
`timescale 1ns/100ps
`default_nettype none
module ppc_board_model (
  input  wire logic       clk,
  input  wire logic [2:0] pin_out,
  input  wire logic [2:0] pin_oe,
  input  wire logic [2:0] pull_up_en,
  input  wire logic [2:0] pull_down_en,
  input  wire logic [2:0] ext_oe,
  input  wire logic [2:0] ext_val,
  output logic      [2:0] pin_lvl
);
  logic [2:0] flt;

  // Undriven, unpulled pad wanders every cycle
  always @(posedge clk)
  begin
    flt <= ~flt;
  end

  initial
  begin
    flt = 3'h0;
  end

  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (pin_oe[i])
        pin_lvl[i] = pin_out[i];
      else if (ext_oe[i])
        pin_lvl[i] = ext_val[i];
      else if (pull_up_en[i])
        pin_lvl[i] = 1'h1;
      else if (pull_down_en[i])
        pin_lvl[i] = 1'h0;
      else
        pin_lvl[i] = flt[i];
    end
  end
endmodule
`default_nettype wire

// File: dv/port4_pin_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module port4_pin_control_bench;
  localparam int DIV = 8;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, sdr, sco, sci, osc, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  lvl, pout, poe, pu, pd, pdata, ext_oe, ext_val;
  int          bad_count, n_tests, cyc;

  ppc_port4_pin_control #(.SAMPLE_DIV(DIV)) dut_u (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(lvl), .PIN_OUT(pout), .PIN_OE(poe),
    .PULL_UP_EN(pu), .PULL_DOWN_EN(pd), .PORT_DATA(pdata),
    .SERIAL_DATA_READY(sdr), .SERIAL_CLK_OUT(sco), .SERIAL_CLK_IN(sci),
    .OSC_RC_CLK(osc), .PIN_CHANGE_INTERRUPT(irq));

  ppc_board_model board_u (
    .clk(clk), .pin_out(pout), .pin_oe(poe), .pull_up_en(pu),
    .pull_down_en(pd), .ext_oe(ext_oe), .ext_val(ext_val), .pin_lvl(lvl));

  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    chk(n < 20, 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic wrr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, idx, d, r, e);
    chk(e, 32'h0000_0000);
  endtask

  task automatic allc(input logic [31:0] d);
    for (int i = 0; i < 3; i++)
      wrr(6'(ppc_pkg::IDX_PIN1_CONTROL + i), d);
    cy(2);
  endtask

  task automatic pad(input logic [11:0] e);
    chk({poe, pout, pu, pd}, e);
  endtask

  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    pad(12'h038);
    chk(irq, 1'h0);
    apb(1'h0, ppc_pkg::IDX_PIN2_CONTROL, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    chk(e, 32'h0000_0000);
    apb(1'h0, 6'h3F, 32'h0000_0000, r, e);
    chk(e, 1'h1);
  endtask

  task automatic t_modes();
    pdata <= 3'h5;
    allc(32'h0000_FFF2);
    pad(12'hF40);
    allc(32'h0000_0003);
    pad(12'h400);
    wrr(ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0001);
    allc(32'h0000_0000);
    pad(12'h007);
    allc(32'h0000_0001);
    pad(12'h000);
  endtask

  task automatic t_alt();
    logic [31:0] r;
    logic        e;
    wrr(ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0000);
    sdr <= 1'h1;
    sco <= 1'h1;
    osc <= 1'h1;
    allc(32'h0000_0004);
    cy(3);
    pad(12'hFC0);
    sdr <= 1'h0;
    sco <= 1'h0;
    osc <= 1'h0;
    cy(5);
    pad(12'hE00);
    wrr(ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0002);
    apb(1'h0, ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0002);
    cy(2);
    pad(12'hA10);
    ext_oe <= 3'h2;
    ext_val <= 3'h0;
    cy(5);
    chk(sci, 1'h0);
    ext_val <= 3'h2;
    cy(5);
    chk(sci, 1'h1);
    ext_oe <= 3'h0;
    wrr(ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0000);
  endtask

  task automatic edge_irq(input logic v, input logic exp);
    int n;
    n = 0;
    ext_val <= {2'h0, v};
    while (irq !== 1'h1 && n < 3 * DIV)
    begin
      @(posedge clk);
      n++;
    end
    chk(irq, exp);
    if (exp)
      chk(n <= DIV + 4, 1'h1);
    wrr(ppc_pkg::IDX_PORT_STATUS, 32'h0000_0001);
    cy(1);
    chk(irq, 1'h0);
  endtask

  task automatic t_irq();
    allc(32'h0000_0008);
    cy(3 * DIV);
    wrr(ppc_pkg::IDX_PORT_STATUS, 32'h0000_0001);
    ext_oe <= 3'h1;
    ext_val <= 3'h1;
    edge_irq(1'h0, 1'h1);
    edge_irq(1'h1, 1'h1);
    allc(32'h0000_0000);
    edge_irq(1'h0, 1'h0);
    pdata <= 3'h1;
    allc(32'h0000_000B);
    edge_irq(1'h1, 1'h0);
  endtask

  task automatic t_rerst();
    logic [31:0] r;
    logic        e;
    wrr(ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0003);
    srst <= 1'h1;
    cy(3);
    srst <= 1'h0;
    cy(4);
    pad(12'h038);
    chk(irq, 1'h0);
    apb(1'h0, ppc_pkg::IDX_PORT_CONFIG, 32'h0000_0000, r, e);
    chk(r, 32'h0000_0000);
    apb(1'h0, ppc_pkg::IDX_PORT_STATUS, 32'h0000_0000, r, e);
    chk(r, 32'h0000_000E);
  endtask

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end

  initial
  begin
    {srst, psel, penable, pwrite, sdr, sco, osc} = 7'h7F & 7'h40;
    {paddr, pwdata, pdata, ext_oe, ext_val} = 49'h0;
    {bad_count, n_tests, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    cy(2);
    t_reset();
    t_modes();
    t_alt();
    t_irq();
    t_rerst();
    finish_test();
  end
endmodule
`default_nettype wire
